// >>> hdl/fsp_pkg.sv
// Constants shared by the fan speed and PWM configuration block.
// Assumes a single 125 MHz system clock and an 8-bit register port.
package fsp_pkg;

  // Register port width and offsets
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_FANS = 2;
  localparam logic [7:0] OFS_AIN0_MASK = 8'h58;
  localparam logic [7:0] OFS_AIN1_MASK = 8'h59;
  localparam logic [7:0] OFS_COOLING_OUTPUT_ZERO_SPEED1 = 8'h60;
  localparam logic [7:0] OFS_COOLING_OUTPUT_ONE_SPEED1 = 8'h61;
  localparam logic [7:0] OFS_COOLING_OUTPUT_ZERO_CFG2 = 8'h68;
  localparam logic [7:0] OFS_COOLING_OUTPUT_ONE_CFG2 = 8'h69;
  localparam logic [7:0] OFS_COOLING_OUTPUT_ZERO_TACH = 8'h70;
  localparam logic [7:0] OFS_COOLING_OUTPUT_ONE_TACH = 8'h71;

  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] SPEED1_RST = 8'hff;
  localparam logic [7:0] CFG2_RST = 8'h2f;
  localparam logic [7:0] TACH_RST = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // Field positions
  localparam int NORM_LSB = 0;
  localparam int ALARM_LSB = 4;
  localparam int HP_LSB = 0;
  localparam int FREQ_LSB = 4;
  localparam int OSC_LSB = 6;
  localparam int MASK_COOLING_OUTPUT_ZERO = 0;
  localparam int MASK_COOLING_OUTPUT_ONE = 1;

  // Selector encodings
  localparam logic [1:0] FREQ_15HZ = 2'b00;
  localparam logic [1:0] FREQ_62HZ = 2'b01;
  localparam logic [1:0] FREQ_250HZ = 2'b10;
  localparam logic [1:0] OSC_OFF = 2'b00;
  localparam logic [1:0] OSC_470 = 2'b01;
  localparam logic [1:0] OSC_940 = 2'b10;

  // Speed code to duty mapping: duty is code / 15
  localparam logic [3:0] CODE_FULL = 4'hf;
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [3:0] CODE_THIRD = 4'h5;
  localparam logic [3:0] PWM_LAST_SLOT = 4'he;
  localparam logic [7:0] TACH_SAT = 8'hff;

  // Timing: clock rate, PWM frequencies in mHz, tach oscillators in Hz
  localparam longint CLK_HZ = 125000000;
  localparam longint PWM_STEPS = 15;
  localparam longint PWM_F0_MHZ = 15625;
  localparam longint PWM_F1_MHZ = 62500;
  localparam longint PWM_F2_MHZ = 250000;
  localparam longint PWM_F3_MHZ = 1000000;
  localparam longint OSC_F1_HZ = 470;
  localparam longint OSC_F2_HZ = 940;
  localparam longint OSC_F3_HZ = 1880;
  localparam int SLOT_CYC0 = int'(CLK_HZ * 1000 / (PWM_F0_MHZ * PWM_STEPS));
  localparam int SLOT_CYC1 = int'(CLK_HZ * 1000 / (PWM_F1_MHZ * PWM_STEPS));
  localparam int SLOT_CYC2 = int'(CLK_HZ * 1000 / (PWM_F2_MHZ * PWM_STEPS));
  localparam int SLOT_CYC3 = int'(CLK_HZ * 1000 / (PWM_F3_MHZ * PWM_STEPS));
  localparam int OSC_CYC1 = int'(CLK_HZ / OSC_F1_HZ);
  localparam int OSC_CYC2 = int'(CLK_HZ / OSC_F2_HZ);
  localparam int OSC_CYC3 = int'(CLK_HZ / OSC_F3_HZ);
  localparam int CNT_W = 24;

endpackage

// >>> hdl/fsp_fan_unit.sv
// One fan channel: PWM generator and tach period counter.
// Assumes the tach input is already synchronous to the clock.
module fsp_fan_unit #(
  parameter int SLOT0 = fsp_pkg::SLOT_CYC0,
  parameter int SLOT1 = fsp_pkg::SLOT_CYC1,
  parameter int SLOT2 = fsp_pkg::SLOT_CYC2,
  parameter int SLOT3 = fsp_pkg::SLOT_CYC3,
  parameter int OSC1 = fsp_pkg::OSC_CYC1,
  parameter int OSC2 = fsp_pkg::OSC_CYC2,
  parameter int OSC3 = fsp_pkg::OSC_CYC3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] speed_code,
  input wire logic [1:0] freq_sel,
  input wire logic [1:0] osc_sel,
  input wire logic tach_in,
  output logic pwm_out,
  output logic [7:0] tach_result
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] pre;
    logic [3:0] slot;
    logic pwm;
    logic [CNT_W-1:0] osc;
    logic [7:0] cnt;
    logic tach_prev;
    logic [7:0] result;
  } fsp_unit_state_t;

  fsp_unit_state_t s;
  fsp_unit_state_t next_s;

  // Last clock count of one PWM slot for the chosen frequency
  function automatic logic [CNT_W-1:0] slot_last(input logic [1:0] sel);
    case (sel)
      FREQ_15HZ: slot_last = CNT_W'(SLOT0 - 1);
      FREQ_62HZ: slot_last = CNT_W'(SLOT1 - 1);
      FREQ_250HZ: slot_last = CNT_W'(SLOT2 - 1);
      default: slot_last = CNT_W'(SLOT3 - 1);
    endcase
  endfunction

  // Last clock count of one tach oscillator period
  function automatic logic [CNT_W-1:0] osc_last(input logic [1:0] sel);
    case (sel)
      OSC_470: osc_last = CNT_W'(OSC1 - 1);
      OSC_940: osc_last = CNT_W'(OSC2 - 1);
      default: osc_last = CNT_W'(OSC3 - 1);
    endcase
  endfunction

  // Next-state logic for PWM and tach
  always_comb begin
    next_s = s;
    next_s.tach_prev = tach_in;
    if (s.pre >= slot_last(freq_sel)) begin // RULE_09
      next_s.pre = '0;
      next_s.slot = (s.slot >= PWM_LAST_SLOT) ? '0 : s.slot + 4'h1;
    end else begin
      next_s.pre = s.pre + CNT_W'(1);
    end
    // High for code slots out of 15: monotonic, all ones is full drive
    next_s.pwm = (next_s.slot < speed_code); // RULE_15 RULE_05
    if (osc_sel == OSC_OFF) begin
      next_s.osc = '0; // RULE_11
      next_s.cnt = '0;
    end else begin
      if (s.osc >= osc_last(osc_sel)) begin // RULE_10
        next_s.osc = '0;
        if (s.cnt != TACH_SAT) begin
          next_s.cnt = s.cnt + 8'h01; // RULE_13
        end
      end else begin
        next_s.osc = s.osc + CNT_W'(1);
      end
      // Rising tach edge closes one measurement
      if (tach_in && !s.tach_prev) begin
        next_s.result = s.cnt; // RULE_12
        next_s.cnt = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pwm_out = s.pwm;
  assign tach_result = s.result;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tach_off_hold: assert property ((osc_sel == OSC_OFF) |=> (s.cnt == '0) && $stable(s.result)) // RULE_11
    else $error("tach state moved while measurement disabled");
  chk_tach_edge_cap: assert property ((osc_sel != OSC_OFF) && tach_in && !s.tach_prev
      |=> (tach_result == $past(s.cnt)) && (s.cnt == '0)) // RULE_13
    else $error("tach edge did not capture the running count");
  chk_pwm_full_on: assert property ((speed_code == CODE_FULL) |=> pwm_out) // RULE_15
    else $error("full speed code left output low");
  chk_pwm_zero_off: assert property ((speed_code == CODE_ZERO) |=> !pwm_out) // RULE_15
    else $error("zero speed code drove output high");

endmodule

// >>> hdl/fsp_top.sv
// Fan speed and PWM configuration for a two-fan controller.
// Assumes a synchronous 8-bit register port from the serial bus block,
// and alarm, hot-plug and automatic-control requests from neighbours.
// Notes on behaviour
// RULE_01: An alarm-speed request from an analog channel moves fan zero only when that channel's mask bit 0 is set.
// RULE_02: An alarm-speed request from an analog channel moves fan one only when that channel's mask bit 1 is set.
// RULE_03: The low nibble of the first speed register is the normal speed used when no alarm or hot-plug event applies.
// RULE_04: In automatic control the same low nibble is a floor below which the fan is never driven; the code does not apply it to alarm or hot-plug speeds.
// RULE_05: Speed code five gives about one third duty and is the suggested minimum.
// RULE_06: The high nibble of the first speed register is the alarm speed used when an alarm selects it.
// RULE_07: The low nibble of the second speed register is the speed of the other fans while this fan is removed.
// RULE_08: A fan that is hot-plug installed runs at its normal speed, not alarm or hot-plug speed.
// RULE_09: Bits 5 to 4 of the second speed register choose 15.625, 62.5, 250 or 1000 Hz PWM.
// RULE_10: Bits 7 to 6 of the second speed register choose a 470, 940 or 1880 Hz tach oscillator.
// RULE_11: Oscillator select 00 turns tach measurement for that fan off.
// RULE_12: Each fan has a read-only 8-bit tach register with its latest measurement.
// RULE_13: The tach count is oscillator periods between tach pulses, larger for slower fans.
// RULE_14: An analog channel requests alarm speed when its enable bit is set and it is above its high limit.
// RULE_15: Speed codes map to duty cycle monotonically, with all ones giving full drive.
// RULE_16: Mask bits 2 to 7 are plain storage with no effect on the fans.
module fsp_top #(
  parameter int SLOT_CYC_15HZ = fsp_pkg::SLOT_CYC0,
  parameter int SLOT_CYC_62HZ = fsp_pkg::SLOT_CYC1,
  parameter int SLOT_CYC_250HZ = fsp_pkg::SLOT_CYC2,
  parameter int SLOT_CYC_1KHZ = fsp_pkg::SLOT_CYC3,
  parameter int OSC_CYC_470 = fsp_pkg::OSC_CYC1,
  parameter int OSC_CYC_940 = fsp_pkg::OSC_CYC2,
  parameter int OSC_CYC_1880 = fsp_pkg::OSC_CYC3
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [fsp_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [fsp_pkg::DATA_W-1:0] REG_WDATA,
  output logic [fsp_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic [1:0] ANALOG_INPUT_CHANNEL_OVER_HI,
  input wire logic [1:0] ANALOG_INPUT_CHANNEL_ALARM_EN,
  input wire logic AUTO_MODE,
  input wire logic [3:0] AUTO_SPEED_ZERO,
  input wire logic [3:0] AUTO_SPEED_ONE,
  input wire logic [1:0] COOLING_OUTPUT_REMOVED,
  input wire logic [1:0] COOLING_OUTPUT_INSTALLED,
  input wire logic [1:0] COOLING_OUTPUT_TACH,
  output logic [1:0] COOLING_OUTPUT_PWM,
  output logic [1:0][3:0] COOLING_OUTPUT_CODE
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [NUM_FANS-1:0][7:0] mask;
    logic [NUM_FANS-1:0][7:0] speed1;
    logic [NUM_FANS-1:0][7:0] cfg2;
    logic [NUM_FANS-1:0][3:0] code;
    logic [7:0] rdata;
  } fsp_state_t;

  fsp_state_t s;
  fsp_state_t next_s;
  logic [1:0] alarm_req;
  logic [NUM_FANS-1:0][7:0] tach_val;
  logic [3:0] auto_req [NUM_FANS];

  // Larger of two speed codes
  function automatic logic [3:0] code_max(input logic [3:0] a, input logic [3:0] b);
    code_max = (a > b) ? a : b;
  endfunction

  // Speed code for fan i from its settings and the current conditions
  function automatic logic [3:0] pick_code(
    input int i,
    input fsp_state_t st,
    input logic [1:0] req,
    input logic auto_on,
    input logic [3:0] auto_code,
    input logic [1:0] removed,
    input logic [1:0] installed
  );
    logic [3:0] normal;
    logic alarm_hit;
    int other;
    normal = st.speed1[i][NORM_LSB +: 4]; // RULE_03
    alarm_hit = 1'b0;
    other = (i == 0) ? 1 : 0;
    // Per-channel mask selects which fans follow the alarm
    for (int c = 0; c < 2; c++) begin
      if (req[c] && st.mask[c][i]) begin // RULE_01 RULE_02 RULE_16
        alarm_hit = 1'b1;
      end
    end
    if (auto_on) begin
      normal = code_max(auto_code, normal); // RULE_04
    end
    if (installed[i]) begin
      pick_code = normal; // RULE_08
    end else if (removed[other]) begin
      pick_code = st.cfg2[other][HP_LSB +: 4]; // RULE_07
    end else if (alarm_hit) begin
      pick_code = st.speed1[i][ALARM_LSB +: 4]; // RULE_06
    end else begin
      pick_code = normal;
    end
  endfunction

  // Alarm requests from analog channels
  assign alarm_req = ANALOG_INPUT_CHANNEL_OVER_HI & ANALOG_INPUT_CHANNEL_ALARM_EN; // RULE_14
  assign auto_req[0] = AUTO_SPEED_ZERO;
  assign auto_req[1] = AUTO_SPEED_ONE;

  // Register writes, read data and speed selection
  always_comb begin
    next_s = s;
    if (REG_WR) begin
      if (REG_ADDR == OFS_AIN0_MASK) begin
        next_s.mask[0] = REG_WDATA;
      end else if (REG_ADDR == OFS_AIN1_MASK) begin
        next_s.mask[1] = REG_WDATA;
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ZERO_SPEED1) begin
        next_s.speed1[0] = REG_WDATA;
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ONE_SPEED1) begin
        next_s.speed1[1] = REG_WDATA;
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ZERO_CFG2) begin
        next_s.cfg2[0] = REG_WDATA;
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ONE_CFG2) begin
        next_s.cfg2[1] = REG_WDATA;
      end
    end
    // Tach registers are read-only; writes there fall through
    if (REG_RD) begin
      if (REG_ADDR == OFS_AIN0_MASK) begin
        next_s.rdata = s.mask[0];
      end else if (REG_ADDR == OFS_AIN1_MASK) begin
        next_s.rdata = s.mask[1];
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ZERO_SPEED1) begin
        next_s.rdata = s.speed1[0];
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ONE_SPEED1) begin
        next_s.rdata = s.speed1[1];
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ZERO_CFG2) begin
        next_s.rdata = s.cfg2[0];
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ONE_CFG2) begin
        next_s.rdata = s.cfg2[1];
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ZERO_TACH) begin
        next_s.rdata = tach_val[0]; // RULE_12
      end else if (REG_ADDR == OFS_COOLING_OUTPUT_ONE_TACH) begin
        next_s.rdata = tach_val[1]; // RULE_12
      end else begin
        next_s.rdata = RDATA_NONE;
      end
    end
    for (int i = 0; i < NUM_FANS; i++) begin
      next_s.code[i] = pick_code(i, s, alarm_req, AUTO_MODE, auto_req[i],
                                 COOLING_OUTPUT_REMOVED, COOLING_OUTPUT_INSTALLED);
    end
  end

  // State register with documented power-on values
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s.mask <= {NUM_FANS{MASK_RST}};
      s.speed1 <= {NUM_FANS{SPEED1_RST}};
      s.cfg2 <= {NUM_FANS{CFG2_RST}};
      s.code <= '0;
      s.rdata <= RDATA_NONE;
    end else begin
      s <= next_s;
    end
  end

  // One PWM and tach channel per fan
  for (genvar g = 0; g < NUM_FANS; g++) begin : g_fan
    fsp_fan_unit #(
      .SLOT0(SLOT_CYC_15HZ),
      .SLOT1(SLOT_CYC_62HZ),
      .SLOT2(SLOT_CYC_250HZ),
      .SLOT3(SLOT_CYC_1KHZ),
      .OSC1(OSC_CYC_470),
      .OSC2(OSC_CYC_940),
      .OSC3(OSC_CYC_1880)
    ) u_unit (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .speed_code(s.code[g]),
      .freq_sel(s.cfg2[g][FREQ_LSB +: 2]), // RULE_09
      .osc_sel(s.cfg2[g][OSC_LSB +: 2]), // RULE_10
      .tach_in(COOLING_OUTPUT_TACH[g]),
      .pwm_out(COOLING_OUTPUT_PWM[g]),
      .tach_result(tach_val[g])
    );
  end

  // Outputs from flip-flops
  assign REG_RDATA = s.rdata;
  assign COOLING_OUTPUT_CODE = s.code;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Quiet means no hot-plug event and no automatic control
  logic quiet;
  assign quiet = (COOLING_OUTPUT_REMOVED == 2'b00) && (COOLING_OUTPUT_INSTALLED == 2'b00) && !AUTO_MODE;

  chk_alarm_fan_zero: assert property (quiet && |(alarm_req & {s.mask[1][MASK_COOLING_OUTPUT_ZERO], s.mask[0][MASK_COOLING_OUTPUT_ZERO]})
      |=> COOLING_OUTPUT_CODE[0] == $past(s.speed1[0][ALARM_LSB +: 4])) // RULE_01
    else $error("fan zero not at alarm speed");
  chk_alarm_fan_one: assert property (quiet && |(alarm_req & {s.mask[1][MASK_COOLING_OUTPUT_ONE], s.mask[0][MASK_COOLING_OUTPUT_ONE]})
      |=> COOLING_OUTPUT_CODE[1] == $past(s.speed1[1][ALARM_LSB +: 4])) // RULE_02
    else $error("fan one not at alarm speed");
  chk_normal_no_alarm: assert property (quiet && !(|(alarm_req & {s.mask[1][MASK_COOLING_OUTPUT_ZERO], s.mask[0][MASK_COOLING_OUTPUT_ZERO]}))
      |=> COOLING_OUTPUT_CODE[0] == $past(s.speed1[0][NORM_LSB +: 4])) // RULE_03
    else $error("unmasked fan left normal speed");
  chk_auto_floor: assert property (AUTO_MODE && (COOLING_OUTPUT_INSTALLED[1] || COOLING_OUTPUT_REMOVED == 2'b00)
      && (alarm_req == 2'b00)
      |=> COOLING_OUTPUT_CODE[1] >= $past(s.speed1[1][NORM_LSB +: 4])) // RULE_04
    else $error("automatic speed fell below the minimum");
  chk_hotplug_other: assert property (COOLING_OUTPUT_REMOVED[1] && !COOLING_OUTPUT_INSTALLED[0]
      |=> COOLING_OUTPUT_CODE[0] == $past(s.cfg2[1][HP_LSB +: 4])) // RULE_07
    else $error("remaining fan not at hot-plug speed");
  chk_install_normal: assert property (COOLING_OUTPUT_INSTALLED[0] && !AUTO_MODE
      |=> COOLING_OUTPUT_CODE[0] == $past(s.speed1[0][NORM_LSB +: 4])) // RULE_08
    else $error("installed fan not at normal speed");
  chk_tach_readback: assert property (REG_RD && (REG_ADDR == OFS_COOLING_OUTPUT_ONE_TACH)
      |=> REG_RDATA == $past(tach_val[1])) // RULE_12
    else $error("tach register read mismatch");
  chk_tach_ro_write: assert property (REG_WR && (REG_ADDR == OFS_COOLING_OUTPUT_ZERO_TACH)
      |=> $stable(s.mask) && $stable(s.speed1) && $stable(s.cfg2)) // RULE_12
    else $error("write to tach register changed storage");

endmodule

// >>> dv/fsp_fan_model.sv
// Behavioural cooling fan: one tach pulse per turn, period in clock cycles.
// Assumes the bench sets the period; zero means the fan stands still.
module fsp_fan_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm,
  input wire logic [15:0] period,
  output logic tach
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  // Two-cycle tach pulse at the start of each turn
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0;
      tach <= 1'b0;
    end else if (period == 16'h0) begin
      cnt <= 16'h0;
      tach <= 1'b0;
    end else begin
      cnt <= (cnt + 16'h1 >= period) ? 16'h0 : cnt + 16'h1;
      tach <= (cnt < 16'h2);
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the fan speed and PWM configuration block.
// Assumes short PWM slot counts and a short 470 Hz oscillator count set through
// parameters; the 940 Hz and 1880 Hz oscillators keep their real periods.
module tb_top;
  import fsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_wr, reg_rd, auto_mode;
  logic [7:0] addr, wdata, rdata, v;
  logic [1:0] over_hi, alarm_en, removed, installed, tach, pwm;
  logic [3:0] auto0, auto1;
  logic [1:0][3:0] code;
  logic [15:0] per0, per1;
  int n_errors = 0;
  int compares = 0;
  int hi, ri;
  int slots[4] = '{8, 4, 2, 1};
  logic [7:0] ra[9] = '{8'h58, 8'h59, 8'h60, 8'h61, 8'h68, 8'h69, 8'h70, 8'h71, 8'h5a};
  logic [7:0] rv[9] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h2f, 8'h2f, 8'h00, 8'h00, 8'h00};

  fsp_top #(.SLOT_CYC_15HZ(8), .SLOT_CYC_62HZ(4), .SLOT_CYC_250HZ(2), .SLOT_CYC_1KHZ(1),
    .OSC_CYC_470(8)) dut_u (
    .SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .ANALOG_INPUT_CHANNEL_OVER_HI(over_hi),
    .ANALOG_INPUT_CHANNEL_ALARM_EN(alarm_en), .AUTO_MODE(auto_mode),
    .AUTO_SPEED_ZERO(auto0), .AUTO_SPEED_ONE(auto1), .COOLING_OUTPUT_REMOVED(removed),
    .COOLING_OUTPUT_INSTALLED(installed), .COOLING_OUTPUT_TACH(tach),
    .COOLING_OUTPUT_PWM(pwm), .COOLING_OUTPUT_CODE(code));
  fsp_fan_model cooling_output_zero_u (.clk(clk), .rst_n(rst_n), .pwm(pwm[0]), .period(per0), .tach(tach[0]));
  fsp_fan_model cooling_output_one_u (.clk(clk), .rst_n(rst_n), .pwm(pwm[1]), .period(per1), .tach(tach[1]));

  // Range compare; exact when both bounds match
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] up);
    compares++;
    if (^got === 1'bx || got < lo || got > up) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h..%h", $time, got, lo, up);
    end
  endtask

  // Register write and read on the strobe port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e, e);
  endtask

  // Applied speed codes of both fans after inputs settle
  task automatic cc(input logic [3:0] e0, input logic [3:0] e1);
    repeat (2) @(negedge clk);
    chk({4'h0, code[0]}, {4'h0, e0}, {4'h0, e0});
    chk({4'h0, code[1]}, {4'h0, e1}, {4'h0, e1});
  endtask

  // High cycles and rising edges of one PWM over 240 cycles
  task automatic meas(input int f, output int h, output int r);
    logic p;
    h = 0;
    r = 0;
    p = pwm[f];
    repeat (240) begin
      @(negedge clk);
      if (pwm[f] === 1'b1) h++;
      if (pwm[f] === 1'b1 && p === 1'b0) r++;
      p = pwm[f];
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog against a hang
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    over_hi = 2'b00; alarm_en = 2'b00; auto_mode = 1'b0; auto0 = 4'h0; auto1 = 4'h0;
    removed = 2'b00; installed = 2'b00; per0 = 16'h0; per1 = 16'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) rc(ra[i], rv[i]);
    cc(4'hf, 4'hf);
    wr(8'h58, 8'hfd);
    rc(8'h58, 8'hfd);
    wr(8'h70, 8'h55);
    rc(8'h70, 8'h00);
    wr(8'h5a, 8'h12);
    rc(8'h5a, 8'h00);
    wr(8'h60, 8'ha5);
    wr(8'h61, 8'h3c);
    cc(4'h5, 4'hc);
    // Every mask pairing on each channel, reserved bits set
    alarm_en = 2'b11;
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(8'h58, (c == 0) ? {6'h3f, m[1:0]} : 8'h00);
        wr(8'h59, (c == 1) ? {6'h3f, m[1:0]} : 8'h00);
        over_hi = 2'b01 << c;
        cc(m[0] ? 4'ha : 4'h5, m[1] ? 4'h3 : 4'hc);
      end
    end
    alarm_en = 2'b01;
    cc(4'h5, 4'hc);
    over_hi = 2'b01;
    wr(8'h58, 8'h03);
    cc(4'ha, 4'h3);
    // Hot-plug removal and installation during an alarm
    wr(8'h69, 8'he7);
    wr(8'h68, 8'h29);
    removed = 2'b10;
    cc(4'h7, 4'h3);
    removed = 2'b01;
    cc(4'ha, 4'h9);
    removed = 2'b10;
    installed = 2'b01;
    cc(4'h5, 4'h3);
    removed = 2'b00; installed = 2'b00; over_hi = 2'b00;
    // Automatic control with the normal nibble as floor
    auto_mode = 1'b1;
    auto0 = 4'h2;
    auto1 = 4'he;
    cc(4'h5, 4'he);
    auto0 = 4'h9;
    auto1 = 4'h1;
    cc(4'h9, 4'hc);
    auto_mode = 1'b0;
    // Duty and period at each PWM frequency select
    for (int f = 0; f < 4; f++) begin
      wr(8'h68, {2'b00, f[1:0], 4'h9});
      repeat (130) @(negedge clk);
      meas(0, hi, ri);
      chk(8'(hi), 8'd80, 8'd80);
      chk(8'(ri), 8'(240 / (slots[f] * 15)), 8'(240 / (slots[f] * 15)));
    end
    meas(1, hi, ri);
    chk(8'(hi), 8'd192, 8'd192);
    chk(8'(ri), 8'd8, 8'd8);
    wr(8'h60, 8'haf);
    repeat (30) @(negedge clk);
    meas(0, hi, ri);
    chk(8'(hi), 8'd240, 8'd240);
    wr(8'h60, 8'ha0);
    repeat (30) @(negedge clk);
    meas(0, hi, ri);
    chk(8'(hi), 8'd0, 8'd0);
    // Tach counts at the 470 Hz oscillator select for three fan speeds
    per0 = 16'd80;
    per1 = 16'd40;
    wr(8'h68, 8'h4f);
    wr(8'h69, 8'h67);
    repeat (250) @(negedge clk);
    rd(8'h71, v);
    chk(v, 8'd4, 8'd6);
    rd(8'h70, v);
    chk(v, 8'd9, 8'd11);
    per0 = 16'd160;
    repeat (400) @(negedge clk);
    rd(8'h70, v);
    chk(v, 8'd19, 8'd21);
    // Slow oscillators give no tick within these short tach periods
    wr(8'h68, 8'h8f);
    repeat (400) @(negedge clk);
    rc(8'h70, 8'(160 / OSC_CYC2));
    rd(8'h71, v);
    wr(8'h69, 8'h2f);
    per1 = 16'd80;
    repeat (250) @(negedge clk);
    rc(8'h71, v);
    wr(8'h69, 8'he7);
    per1 = 16'd40;
    repeat (250) @(negedge clk);
    rc(8'h71, 8'(40 / OSC_CYC3));
    // Very slow fan saturates the count
    wr(8'h68, 8'h4f);
    per0 = 16'd4000;
    repeat (8500) @(negedge clk);
    rc(8'h70, 8'hff);
    finish_test();
  end
endmodule
